// *** rtl/pais_axis_io.sv ***
// Positioning axis I/O: input conditioning, motion sequencing, pulse outputs
// Function
// - Origin pulse marks the reference point
// - Origin pulse taken on rising edge only
// - Stopper method: origin edge completes return
// - Mode switch edge moves speed to position
// - Drive not ready sets return-request flag
// - Ready loss during motion stops the axis
// - No automatic restart after ready loss
// - Ready going off clears return-done flag
// - Unassigned ready or limits read as on
// - Near cam detected on rising edge
// - Either stroke limit off stops positioning
// - Retry: upper limit bounds forward search
// - Retry: lower limit bounds reverse search
// - Counter clear driven except second counting method
// - Pulse trains with direction on two outputs
// - Sign on forward; reverse pulses 100 us later
// - Quadrature: B lags forward, A lags reverse
// - CW/CCW: pulses on direction's own output
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pais_axis_io #(
  parameter int unsigned DIR_DELAY_CYC = pais_pkg::DIR_DELAY_CYC
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        ORIGIN_PULSE_IN_I,
  input  wire logic        NEAR_CAM_IN_I,
  input  wire logic        UPPER_STROKE_LIMIT_IN_I,
  input  wire logic        LOWER_STROKE_LIMIT_IN_I,
  input  wire logic        DRIVE_READY_IN_I,
  input  wire logic        MODE_SWITCH_CMD_IN_I,
  output logic             PULSE_FWD_O,
  output logic             PULSE_REV_O,
  output logic             COUNTER_CLEAR_O
);
  localparam int NI = pais_pkg::NUM_IN;
  localparam int CW = pais_pkg::CNT_W;

  pais_pkg::pais_in_type    raw, sync1_ff, sync2_ff, filt_ff, eff, eff_d_ff, rise, fall;
  pais_pkg::pais_state_type st_ff;
  pais_pkg::pais_pmode_type pmode_ff;
  pais_pkg::pais_ometh_type ometh_ff;
  logic [7:0]    flt_cnt_ff [NI];
  logic [7:0]    flt_ff;
  logic [2:0]    asg_ff;
  logic          retry_ff, spd_mode_ff;
  logic [31:0]   count_ff, remain_ff, rd_data;
  logic [15:0]   period_ff, hp_cnt_ff, per_m1;
  logic [CW-1:0] wait_ff, clr_cnt_ff, so_cnt_ff;
  logic          dir_ff, orig_ff, cam_seen_ff, spd_act_ff, phase_ff;
  logic [1:0]    quad_ff;
  logic          origin_return_request_flag_ff, origin_return_done_flag_ff, stop_err_ff;
  logic          setup, wr_go, cmd_start, cmd_orig, cmd_abort, cmd_dir, w1c;
  logic          ok_to_go, go, halt, limit_halt, retry_turn, orig_fin, pos_done;
  logic          run, busy, tick, step;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [CW-1:0] dly(input pais_pkg::pais_pmode_type m,
                                        input logic fwd);
    return (m == pais_pkg::PM_PSIGN && !fwd) ? CW'(DIR_DELAY_CYC - 1) : '0;
  endfunction

  // Quadrature step: forward lets A lead, reverse lets B lead
  function automatic logic [1:0] qstep(input logic [1:0] q, input logic fwd);
    return fwd ? {~q[0], q[1]} : {q[0], ~q[1]};
  endfunction

  assign raw = {MODE_SWITCH_CMD_IN_I, DRIVE_READY_IN_I, LOWER_STROKE_LIMIT_IN_I,
                UPPER_STROKE_LIMIT_IN_I, NEAR_CAM_IN_I, ORIGIN_PULSE_IN_I};

  // Two-stage synchroniser on all pins
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= raw;
      sync2_ff <= sync1_ff;
    end
  end

  // Response-time filter: a change must persist for the set cycles
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      filt_ff <= '0;
      for (int i = 0; i < NI; i++) flt_cnt_ff[i] <= '0;
    end else begin
      for (int i = 0; i < NI; i++) begin
        if (sync2_ff[i] == filt_ff[i]) begin
          flt_cnt_ff[i] <= '0;
        end else if (flt_cnt_ff[i] >= flt_ff) begin
          filt_ff[i]    <= sync2_ff[i];
          flt_cnt_ff[i] <= '0;
        end else begin
          flt_cnt_ff[i] <= flt_cnt_ff[i] + 8'h01;
        end
      end
    end
  end

  // Unassigned inputs forced on, then edge detection
  always_comb begin
    eff = filt_ff;
    eff.ready = filt_ff.ready | ~asg_ff[pais_pkg::ASG_READY];
    eff.upper_stroke_limit_in = filt_ff.upper_stroke_limit_in | ~asg_ff[pais_pkg::ASG_UPPER];
    eff.lower_stroke_limit_in = filt_ff.lower_stroke_limit_in | ~asg_ff[pais_pkg::ASG_LOWER];
  end
  assign rise = eff & ~eff_d_ff;
  assign fall = ~eff & eff_d_ff;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) eff_d_ff <= '0;
    else eff_d_ff <= eff;
  end

  // Bus decode and commands
  assign setup     = PSEL_I & ~PENABLE_I;
  assign wr_go     = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
  assign cmd_start = wr_go & hit(PADDR_I, pais_pkg::OFF_CTRL) & PWDATA_I[pais_pkg::CTRL_START_BIT];
  assign cmd_orig  = wr_go & hit(PADDR_I, pais_pkg::OFF_CTRL) & PWDATA_I[pais_pkg::CTRL_ORIG_BIT];
  assign cmd_abort = wr_go & hit(PADDR_I, pais_pkg::OFF_CTRL) & PWDATA_I[pais_pkg::CTRL_ABORT_BIT];
  assign cmd_dir   = PWDATA_I[pais_pkg::CTRL_DIR_BIT];
  assign w1c       = wr_go & hit(PADDR_I, pais_pkg::OFF_STATUS);

  // Motion conditions
  assign run        = st_ff == pais_pkg::ST_RUN;
  assign busy       = st_ff != pais_pkg::ST_IDLE;
  assign ok_to_go   = eff.ready & eff.upper_stroke_limit_in & eff.lower_stroke_limit_in;
  assign go         = (st_ff == pais_pkg::ST_IDLE) & (cmd_start | cmd_orig) & ok_to_go & ~cmd_abort;
  assign limit_halt = (~eff.upper_stroke_limit_in | ~eff.lower_stroke_limit_in)
                      & ~(orig_ff & retry_ff);
  assign halt       = ~eff.ready | cmd_abort | limit_halt;
  assign retry_turn = orig_ff & retry_ff
                      & ((dir_ff & ~eff.upper_stroke_limit_in)
                      | (~dir_ff & ~eff.lower_stroke_limit_in));
  assign orig_fin   = run & ~halt & ~retry_turn & orig_ff & rise.origin_pulse_in
                      & (cam_seen_ff | ometh_ff == pais_pkg::OM_STOPPER);
  assign per_m1     = (period_ff == 16'h0000) ? 16'h0000 : period_ff - 16'h0001;
  assign tick       = run & (hp_cnt_ff >= per_m1);
  assign step       = tick & (pmode_ff[1] | phase_ff);
  assign pos_done   = ~orig_ff & ~spd_act_ff
                      & (remain_ff == 32'h0000_0000 | (step & remain_ff == 32'h0000_0001));

  // Axis sequencer; halts return to idle and wait for a new command
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_ff       <= pais_pkg::ST_IDLE;
      dir_ff      <= 1'b0;
      orig_ff     <= 1'b0;
      cam_seen_ff <= 1'b0;
      spd_act_ff  <= 1'b0;
      remain_ff   <= '0;
      wait_ff     <= '0;
    end else begin
      unique case (st_ff)
        pais_pkg::ST_IDLE: begin
          if (go) begin
            st_ff       <= pais_pkg::ST_SETUP;
            dir_ff      <= cmd_dir;
            orig_ff     <= cmd_orig;
            cam_seen_ff <= 1'b0;
            spd_act_ff  <= ~cmd_orig & spd_mode_ff;
            remain_ff   <= count_ff;
            wait_ff     <= dly(pmode_ff, cmd_dir);
          end
        end
        pais_pkg::ST_SETUP: begin
          if (halt) st_ff <= pais_pkg::ST_IDLE;
          else if (wait_ff == '0) st_ff <= pais_pkg::ST_RUN;
          else wait_ff <= wait_ff - CW'(1);
        end
        pais_pkg::ST_RUN: begin
          if (halt) begin
            st_ff <= pais_pkg::ST_IDLE;
          end else if (retry_turn) begin
            dir_ff  <= ~dir_ff;
            st_ff   <= pais_pkg::ST_SETUP;
            wait_ff <= dly(pmode_ff, ~dir_ff);
          end else if (orig_fin | pos_done) begin
            st_ff <= pais_pkg::ST_IDLE;
            // Last pulse counted too, so remain reads zero when done
            if (step & remain_ff != 32'h0000_0000) remain_ff <= remain_ff - 32'h0000_0001;
          end else begin
            if (rise.cam) cam_seen_ff <= 1'b1;
            if (rise.mode_switch_cmd_in) spd_act_ff <= 1'b0;
            if (step & ~spd_act_ff) remain_ff <= remain_ff - 32'h0000_0001;
          end
        end
        default: st_ff <= pais_pkg::ST_IDLE;
      endcase
    end
  end

  // Half-period timer, phase and quadrature state
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hp_cnt_ff <= '0;
      phase_ff  <= 1'b0;
      quad_ff   <= 2'h0;
    end else if (!run) begin
      hp_cnt_ff <= '0;
      phase_ff  <= 1'b0;
    end else if (tick) begin
      hp_cnt_ff <= '0;
      phase_ff  <= ~phase_ff;
      if (pmode_ff[1]) quad_ff <= qstep(quad_ff, dir_ff);
    end else begin
      hp_cnt_ff <= hp_cnt_ff + 16'h0001;
    end
  end

  // Pulse output encoding per mode
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PULSE_FWD_O <= 1'b0;
      PULSE_REV_O <= 1'b0;
    end else begin
      unique case (pmode_ff)
        pais_pkg::PM_CWCCW: begin
          PULSE_FWD_O <= run & dir_ff & phase_ff;
          PULSE_REV_O <= run & ~dir_ff & phase_ff;
        end
        pais_pkg::PM_PSIGN: begin
          PULSE_FWD_O <= run & phase_ff;
          PULSE_REV_O <= busy & dir_ff;
        end
        default: begin
          PULSE_FWD_O <= quad_ff[1];
          PULSE_REV_O <= quad_ff[0];
        end
      endcase
    end
  end

  // Counter clear pulse at end of origin return, except with the second counting method
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      clr_cnt_ff      <= '0;
      COUNTER_CLEAR_O <= 1'b0;
    end else if (orig_fin & ometh_ff != pais_pkg::OM_COUNT2) begin
      clr_cnt_ff      <= CW'(pais_pkg::CLEAR_CYC - 1);
      COUNTER_CLEAR_O <= 1'b1;
    end else if (clr_cnt_ff != '0) begin
      clr_cnt_ff <= clr_cnt_ff - CW'(1);
    end else begin
      COUNTER_CLEAR_O <= 1'b0;
    end
  end

  // Status flags; a hardware set wins over a software clear
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      origin_return_request_flag_ff <= 1'b0;
      origin_return_done_flag_ff    <= 1'b0;
      stop_err_ff                   <= 1'b0;
    end else begin
      if (~eff.ready) origin_return_request_flag_ff <= 1'b1;
      else if (orig_fin | (w1c & PWDATA_I[pais_pkg::SB_REQ]))
        origin_return_request_flag_ff <= 1'b0;
      if (orig_fin) origin_return_done_flag_ff <= 1'b1;
      else if (fall.ready | (w1c & PWDATA_I[pais_pkg::SB_DONE]))
        origin_return_done_flag_ff <= 1'b0;
      if (busy & halt & ~cmd_abort) stop_err_ff <= 1'b1;
      else if (w1c & PWDATA_I[pais_pkg::SB_STOP]) stop_err_ff <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pmode_ff    <= pais_pkg::PM_CWCCW;
      ometh_ff    <= pais_pkg::OM_CAM;
      retry_ff    <= 1'b0;
      spd_mode_ff <= 1'b0;
      asg_ff      <= pais_pkg::ASG_RST;
      flt_ff      <= pais_pkg::FLT_RST;
      count_ff    <= pais_pkg::COUNT_RST;
      period_ff   <= pais_pkg::PERIOD_RST;
    end else if (wr_go) begin
      if (hit(PADDR_I, pais_pkg::OFF_CFG)) begin
        pmode_ff    <= pais_pkg::pais_pmode_type'(PWDATA_I[pais_pkg::CFG_PMODE_LSB +: 2]);
        ometh_ff    <= pais_pkg::pais_ometh_type'(PWDATA_I[pais_pkg::CFG_METH_LSB +: 2]);
        retry_ff    <= PWDATA_I[pais_pkg::CFG_RETRY_BIT];
        spd_mode_ff <= PWDATA_I[pais_pkg::CFG_SPD_BIT];
        asg_ff      <= PWDATA_I[pais_pkg::CFG_ASG_LSB +: 3];
        flt_ff      <= PWDATA_I[pais_pkg::CFG_FLT_LSB +: 8];
      end
      if (hit(PADDR_I, pais_pkg::OFF_COUNT)) count_ff <= PWDATA_I;
      if (hit(PADDR_I, pais_pkg::OFF_PERIOD)) period_ff <= PWDATA_I[15:0];
    end
  end

  // Read mux
  always_comb begin
    rd_data = '0;
    if (hit(PADDR_I, pais_pkg::OFF_CFG)) begin
      rd_data[pais_pkg::CFG_PMODE_LSB +: 2] = pmode_ff;
      rd_data[pais_pkg::CFG_METH_LSB +: 2]  = ometh_ff;
      rd_data[pais_pkg::CFG_RETRY_BIT]      = retry_ff;
      rd_data[pais_pkg::CFG_SPD_BIT]        = spd_mode_ff;
      rd_data[pais_pkg::CFG_ASG_LSB +: 3]   = asg_ff;
      rd_data[pais_pkg::CFG_FLT_LSB +: 8]   = flt_ff;
    end else if (hit(PADDR_I, pais_pkg::OFF_COUNT)) begin
      rd_data = count_ff;
    end else if (hit(PADDR_I, pais_pkg::OFF_PERIOD)) begin
      rd_data[15:0] = period_ff;
    end else if (hit(PADDR_I, pais_pkg::OFF_STATUS)) begin
      rd_data[pais_pkg::SB_BUSY]      = busy;
      rd_data[pais_pkg::SB_REQ]       = origin_return_request_flag_ff;
      rd_data[pais_pkg::SB_DONE]      = origin_return_done_flag_ff;
      rd_data[pais_pkg::SB_STOP]      = stop_err_ff;
      rd_data[pais_pkg::SB_SPD]       = spd_act_ff;
      rd_data[pais_pkg::SB_DIR]       = dir_ff;
      rd_data[pais_pkg::SB_IN +: NI]  = eff;
    end else if (hit(PADDR_I, pais_pkg::OFF_REMAIN)) begin
      rd_data = remain_ff;
    end
  end

  // APB answer: one wait-free access, registered in the setup cycle
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRDATA_O  <= '0;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= setup;
      PRDATA_O  <= (setup & ~PWRITE_I) ? rd_data : 32'h0000_0000;
      PSLVERR_O <= setup & ~(hit(PADDR_I, pais_pkg::OFF_CTRL) | hit(PADDR_I, pais_pkg::OFF_CFG)
                   | hit(PADDR_I, pais_pkg::OFF_COUNT) | hit(PADDR_I, pais_pkg::OFF_PERIOD)
                   | hit(PADDR_I, pais_pkg::OFF_STATUS) | hit(PADDR_I, pais_pkg::OFF_REMAIN));
    end
  end

  // Cycles the sign output has been off, for the reversal check
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) so_cnt_ff <= '0;
    else if (PULSE_REV_O) so_cnt_ff <= '0;
    else if (so_cnt_ff != '1) so_cnt_ff <= so_cnt_ff + CW'(1);
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_ready_loss;
    busy ##0 !eff.ready;
  endsequence

  a_ready_loss_stop: assert property (s_ready_loss |=> st_ff == pais_pkg::ST_IDLE)
    else $error("axis kept moving after ready loss");
  a_no_auto_start: assert property (!busy && !go |=> !busy)
    else $error("axis started without a command");
  a_request_set: assert property (!eff.ready |=> origin_return_request_flag_ff)
    else $error("request flag not set while drive not ready");
  a_done_cleared: assert property (fall.ready |=> !origin_return_done_flag_ff)
    else $error("done flag survived ready going off");
  a_limit_stop: assert property (busy && !orig_ff && !eff.upper_stroke_limit_in
                                 |=> !busy)
    else $error("motion continued past a stroke limit");
  a_origin_edge: assert property ($rose(origin_return_done_flag_ff)
                                  |-> $past(rise.origin_pulse_in))
    else $error("origin return completed without origin edge");
  a_sign_delay: assert property (pmode_ff == pais_pkg::PM_PSIGN && $rose(PULSE_FWD_O)
                                 && !PULSE_REV_O |-> so_cnt_ff >= CW'(DIR_DELAY_CYC))
    else $error("reverse pulse too soon after sign off");
  a_quad_lag: assert property (pmode_ff[1] && $rose(PULSE_FWD_O)
                               |-> PULSE_REV_O == !$past(dir_ff))
    else $error("quadrature phase order wrong");
  a_cw_side: assert property (pmode_ff == pais_pkg::PM_CWCCW && PULSE_REV_O
                              |-> !$past(dir_ff) && !PULSE_FWD_O)
    else $error("reverse pulse while moving forward");
  a_clear_width: assert property ($rose(COUNTER_CLEAR_O) |-> $past(ometh_ff) != pais_pkg::OM_COUNT2
                                  ##0 COUNTER_CLEAR_O [*8])
    else $error("counter clear wrong for method or too short");
  a_idle_quiet: assert property (!$past(busy) && !pmode_ff[1] && $stable(pmode_ff)
                                 |-> !PULSE_FWD_O && !PULSE_REV_O)
    else $error("pulse output active while idle");
endmodule
`default_nettype wire

// *** rtl/pais_pkg.sv ***
// Constants and types of the positioning axis I/O block
package pais_pkg;
  // Timing: figures in their own unit, counts derived from the clock rate
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned DIR_DELAY_US  = 100;
  localparam int unsigned DIR_DELAY_CYC = DIR_DELAY_US * CLK_MHZ;
  localparam int unsigned CLEAR_US      = 10;
  localparam int unsigned CLEAR_CYC     = CLEAR_US * CLK_MHZ;
  localparam int          CNT_W         = 16;
  localparam int          NUM_IN        = 6;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CFG    = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_REMAIN = 8'h14;

  // Command register bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ORIG_BIT  = 1;
  localparam int CTRL_ABORT_BIT = 2;
  localparam int CTRL_DIR_BIT   = 3;

  // Configuration fields
  localparam int CFG_PMODE_LSB = 0;
  localparam int CFG_METH_LSB  = 2;
  localparam int CFG_RETRY_BIT = 4;
  localparam int CFG_SPD_BIT   = 5;
  localparam int CFG_ASG_LSB   = 6;
  localparam int CFG_FLT_LSB   = 16;
  localparam int ASG_READY     = 0;
  localparam int ASG_UPPER     = 1;
  localparam int ASG_LOWER     = 2;

  // Reset values
  localparam logic [2:0]  ASG_RST    = 3'h7;
  localparam logic [7:0]  FLT_RST    = 8'h04;
  localparam logic [31:0] COUNT_RST  = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RST = 16'h0064;

  // Status bits
  localparam int SB_BUSY = 0;
  localparam int SB_REQ  = 1;
  localparam int SB_DONE = 2;
  localparam int SB_STOP = 3;
  localparam int SB_SPD  = 4;
  localparam int SB_DIR  = 5;
  localparam int SB_IN   = 8;

  typedef enum logic [1:0] {
    PM_CWCCW = 2'h0, PM_PSIGN = 2'h1, PM_QUAD1 = 2'h2, PM_QUAD4 = 2'h3
  } pais_pmode_type;

  typedef enum logic [1:0] {
    OM_CAM = 2'h0, OM_STOPPER = 2'h1, OM_COUNT1 = 2'h2, OM_COUNT2 = 2'h3
  } pais_ometh_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_SETUP = 3'h2, ST_RUN = 3'h4
  } pais_state_type;

  typedef struct packed {
    logic mode_switch_cmd_in;
    logic ready;
    logic lower_stroke_limit_in;
    logic upper_stroke_limit_in;
    logic cam;
    logic origin_pulse_in;
  } pais_in_type;
endpackage

// *** sim/pais_drv_model.sv ***
// Drive unit model: ready after a lag, droop counter
`timescale 1ns/1ps
`default_nettype none
module pais_drv_model #(
  parameter int LAG = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ok_i,
  input  wire logic fwd_i,
  input  wire logic clr_i,
  output logic      rdy_o,
  output int        droop_o
);
  logic [7:0] sh_ff;
  logic       fwd_ff;
  // Health history, ready rises late but drops at once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_ff <= 8'h00;
    end else begin
      sh_ff <= {sh_ff[6:0], ok_i};
    end
  end
  assign rdy_o = sh_ff[LAG] & ok_i;
  // Droop grows with forward pulses
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fwd_ff  <= 1'b0;
      droop_o <= 0;
    end else begin
      fwd_ff <= fwd_i;
      if (clr_i) begin
        droop_o <= 0;
      end else if (fwd_i && !fwd_ff) begin
        droop_o <= droop_o + 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench of the positioning axis I/O block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int DD = 20;
  localparam logic [31:0] BASE = 32'h0004_01C0;
  logic        clk, rst_n, psel, pen, pwr, org, cam, up, lo, ok, msw;
  logic        rdy, prdy, perr, pf, pr, pc, perr_s;
  logic        pf_d = 1'b0, pr_d = 1'b0, pc_d = 1'b0;
  logic [7:0]  pa;
  logic [31:0] pwd, prd, q;
  int          n_fail = 0, n_tests = 0, nf = 0, nr = 0, nc = 0, tmo = 0, droop;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  pais_axis_io #(.DIR_DELAY_CYC(DD)) uut (
    .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .ORIGIN_PULSE_IN_I(org),
    .NEAR_CAM_IN_I(cam), .UPPER_STROKE_LIMIT_IN_I(up),
    .LOWER_STROKE_LIMIT_IN_I(lo), .DRIVE_READY_IN_I(rdy),
    .MODE_SWITCH_CMD_IN_I(msw), .PULSE_FWD_O(pf), .PULSE_REV_O(pr),
    .COUNTER_CLEAR_O(pc));

  pais_drv_model drv (.clk_i(clk), .rst_n_i(rst_n), .ok_i(ok), .fwd_i(pf),
    .clr_i(pc), .rdy_o(rdy), .droop_o(droop));

  // Rising-edge counters and run ceiling
  always @(posedge clk) begin
    pf_d <= pf;
    pr_d <= pr;
    pc_d <= pc;
    if (pf && !pf_d) nf <= nf + 1;
    if (pr && !pr_d) nr <= nr + 1;
    if (pc && !pc_d) nc <= nc + 1;
    tmo <= tmo + 1;
    if (tmo == 60000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  // One APB transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    q = prd;
    perr_s = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic st(input string s, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(s, e, q & m);
  endtask

  task automatic go(input logic [31:0] cfg, input logic [31:0] n, input logic [3:0] c);
    apb(1'b1, 8'h04, cfg);
    apb(1'b1, 8'h08, n);
    apb(1'b1, 8'h0C, 32'h0000_0002);
    apb(1'b1, 8'h00, {28'h000_0000, c});
  endtask

  task automatic idle;
    do begin
      apb(1'b0, 8'h10, 32'h0000_0000);
    end while (q[0] !== 1'b0);
  endtask

  // Pin pulse: 0 origin, 1 cam, else mode switch
  task automatic pul(input int w);
    for (int v = 1; v >= 0; v--) begin
      case (w)
        0: org <= v[0];
        1: cam <= v[0];
        default: msw <= v[0];
      endcase
      cy(20);
    end
  endtask

  task automatic t_reset;
    chk("outputs", 32'h0000_0000, {29'h0, pf, pr, pc});
    st("request", 32'h0000_0002, 32'h0000_0002);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("cfg", BASE, q);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("period", 32'h0000_0064, q);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, perr_s});
    cy(20);
    apb(1'b1, 8'h10, 32'h0000_000E);
    st("request", 32'h0000_0002, 32'h0000_0000);
  endtask

  // CW/CCW and sign modes, both directions
  task automatic t_move;
    int ef[4] = '{3, 0, 3, 3};
    int er[4] = '{0, 3, 1, 0};
    int k, f0, r0;
    for (int i = 0; i < 4; i++) begin
      f0 = nf;
      r0 = nr;
      go(BASE | (i >> 1), 32'h0000_0003, (i % 2) ? 4'h1 : 4'h9);
      k = 0;
      while (i == 3 && pf !== 1'b1 && k < 300) begin
        @(posedge clk);
        k++;
      end
      if (i == 3) chk("sign delay", 32'h0000_0001, k >= DD && pf === 1'b1);
      idle();
      chk("fwd pulses", ef[i], nf - f0);
      chk("rev pulses", er[i], nr - r0);
    end
  endtask

  task automatic t_quad;
    int k;
    for (int i = 0; i < 2; i++) begin
      go(BASE | (32'h0000_0002 + i), 32'h0000_0004, i ? 4'h1 : 4'h9);
      k = 0;
      while (pf !== 1'b1 && pr !== 1'b1 && k < 200) begin
        @(posedge clk);
        k++;
      end
      chk("phase lead", i ? 32'h0000_0001 : 32'h0000_0002, {pf, pr});
      idle();
    end
  endtask

  task automatic t_speed;
    go(BASE | 32'h0000_0020, 32'h0000_0003, 4'h9);
    cy(60);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("remain", 32'h0000_0003, q);
    pul(2);
    idle();
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("remain", 32'h0000_0000, q);
  endtask

  task automatic t_origin(input logic [31:0] cfg, input logic need_cam, input int eclr);
    int c0;
    c0 = nc;
    apb(1'b1, 8'h10, 32'h0000_0004);
    org <= 1'b1;
    go(cfg, 32'h0000_0000, 4'hA);
    cy(30);
    st("origin level", 32'h0000_0001, 32'h0000_0001);
    org <= 1'b0;
    cy(20);
    if (need_cam) begin
      pul(0);
      st("before cam", 32'h0000_0001, 32'h0000_0001);
      pul(1);
    end
    pul(0);
    st("done", 32'h0000_0007, 32'h0000_0004);
    chk("clear pulses", eclr, nc - c0);
    cy(2600);
    if (eclr == 1) chk("droop", 32'h0000_0000, droop);
  endtask

  // Retry origin return turns at each limit, then abort
  task automatic t_retry;
    go(BASE | 32'h0000_0010, 32'h0000_0000, 4'hA);
    up <= 1'b0;
    cy(20);
    st("turn at upper", 32'h0000_0021, 32'h0000_0001);
    up <= 1'b1;
    lo <= 1'b0;
    cy(20);
    st("turn at lower", 32'h0000_0021, 32'h0000_0021);
    lo <= 1'b1;
    apb(1'b1, 8'h00, 32'h0000_0004);
    st("abort", 32'h0000_0009, 32'h0000_0000);
  endtask

  // Ready loss, then each limit, in mid-move
  task automatic t_halt;
    int f0;
    for (int i = 0; i < 3; i++) begin
      go(BASE, 32'h0000_00C8, 4'h9);
      cy(30);
      ok <= (i != 0);
      up <= (i != 1);
      lo <= (i != 2);
      cy(30);
      st("halt", i ? 32'h9 : 32'hF, i ? 32'h8 : 32'hA);
      ok <= 1'b1;
      up <= 1'b1;
      lo <= 1'b1;
      f0 = nf;
      cy(40);
      chk("restart", 32'h0000_0000, nf - f0);
      apb(1'b1, 8'h10, 32'h0000_000E);
    end
  endtask

  task automatic t_unasg;
    int f0;
    ok <= 1'b0;
    up <= 1'b0;
    lo <= 1'b0;
    cy(20);
    f0 = nf;
    go(32'h0004_0000, 32'h0000_0002, 4'h9);
    idle();
    chk("forced on", 32'h0000_0002, nf - f0);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    {psel, pen, pwr, org, cam, msw} = 6'h00;
    {up, lo, ok} = 3'h7;
    pa = 8'h00;
    pwd = 32'h0000_0000;
    cy(10);
    rst_n <= 1'b1;
    cy(1);
    t_reset();
    t_move();
    t_quad();
    t_speed();
    t_origin(BASE | 32'h0000_0004, 1'b0, 1);
    t_origin(BASE, 1'b1, 1);
    t_origin(BASE | 32'h0000_000C, 1'b1, 0);
    t_origin(BASE | 32'h0000_0008, 1'b1, 1);
    t_retry();
    t_halt();
    t_unasg();
    print_verdict();
  end
endmodule
`default_nettype wire
